// *** common/ter_pkg.sv ***
// Shared constants and types for the touch electrode readout block.
// Assumes a 25 MHz system clock and a host on the I2C pins.
//
// Behaviour
// [RULE_01] Filtered low bytes of electrodes 0, 1, 2 sit at 0x02, 0x04, 0x06.
// [RULE_02] Filtered high parts of electrodes 0, 1, 2 sit at 0x03, 0x05, 0x07.
// [RULE_03] Low byte register returns bits 7..0 of the 10-bit filtered result.
// [RULE_04] High register returns the top two bits, values zero to three.
// [RULE_05] Baselines of electrodes 0, 1, 2 sit at 0x1a, 0x1b, 0x1c.
// [RULE_06] Baseline register holds the 10-bit baseline with two low bits dropped.
// [RULE_07] One interrupt output is shared by all electrodes.
// [RULE_08] Interrupt asserts whenever the touch status register value changes.
// [RULE_09] Both touch and release on any electrode assert the interrupt.
// [RULE_10] Interrupt is open-drain, active low, latching until cleared.
// [RULE_11] Interrupt releases as soon as the host makes an I2C read.
// [RULE_12] Host services an interrupt by reading the touch status register.
// [RULE_13] Electrode is grounded, then charged at constant current for the charge time.
// [RULE_14] All electrodes other than the measured one are held at ground.
// [RULE_15] After charging the electrode voltage is converted by a 10-bit ADC.
// [RULE_16] After conversion the electrode discharges at the charge rate.
// [RULE_17] Host treats counts outside the valid window as invalid and retunes.
// [RULE_18] Touch status is read-only at 0x00, one bit per electrode in bits 2..0.
// [RULE_19] In three-electrode mode the shared pin is an electrode, no interrupt.
// [RULE_20] Bits 7..2 of each filtered high register read as zero.
package ter_pkg;

  localparam int CLK_PERIOD_NS = 40;

  // Register offsets
  localparam logic [7:0] TOUCH_STATUS_OFS = 8'h00;
  localparam logic [7:0] E0_FILT_LOW_OFS = 8'h02;
  localparam logic [7:0] E0_FILT_HIGH_OFS = 8'h03;
  localparam logic [7:0] E1_FILT_LOW_OFS = 8'h04;
  localparam logic [7:0] E1_FILT_HIGH_OFS = 8'h05;
  localparam logic [7:0] E2_FILT_LOW_OFS = 8'h06;
  localparam logic [7:0] E2_FILT_HIGH_OFS = 8'h07;
  localparam logic [7:0] E0_BASELINE_OFS = 8'h1a;
  localparam logic [7:0] E1_BASELINE_OFS = 8'h1b;
  localparam logic [7:0] E2_BASELINE_OFS = 8'h1c;

  // Field layout
  localparam int ADC_W = 10;
  localparam int NUM_ELEC = 3;
  localparam int FILT_LOW_MSB = 7;
  localparam int FILT_HIGH_LSB = 8;
  localparam int BASE_DROP = 2;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Default 7-bit bus address
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h4a;

  // Timing
  localparam int GROUND_TIME_NS = 1000;
  localparam int GROUND_CYC = (GROUND_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHARGE_BASE_NS = 500;
  localparam int CHARGE_BASE_CYC = (CHARGE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  // Filter reset value
  localparam logic [ADC_W-1:0] FILT_RESET = 10'h000;

  typedef enum logic [1:0] {
    TER_MS_GROUND = 2'b00,
    TER_MS_CHARGE = 2'b01,
    TER_MS_CONVERT = 2'b10,
    TER_MS_DISCHARGE = 2'b11
  } ter_meas_state_t;

  typedef enum logic [2:0] {
    TER_IS_IDLE = 3'b000,
    TER_IS_ADDR = 3'b001,
    TER_IS_ADDR_ACK = 3'b010,
    TER_IS_WRITE = 3'b011,
    TER_IS_WRITE_ACK = 3'b100,
    TER_IS_READ = 3'b101,
    TER_IS_READ_ACK = 3'b110
  } ter_i2c_state_t;

  // Per-electrode analog switch controls
  typedef struct packed {
    logic [NUM_ELEC-1:0] ground;
    logic [NUM_ELEC-1:0] charge;
    logic [NUM_ELEC-1:0] discharge;
  } ter_elec_drive_t;

  // One finished conversion
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [ADC_W-1:0] value;
  } ter_sample_t;

endpackage

// *** hdl/ter_sequencer.sv ***
// Measurement sequencer: ground, charge, convert, discharge per electrode.
// Assumes the ADC wrapper runs on sys_clk and answers adc_start with adc_done.
module ter_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Configuration
  input wire logic three_electrode_mode,
  input wire logic [2:0] charge_time_code,
  // Converter
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ter_pkg::ADC_W-1:0] adc_data,
  // Results
  output ter_pkg::ter_elec_drive_t drive,
  output ter_pkg::ter_sample_t sample
);
  import ter_pkg::*;

  ter_meas_state_t state_reg;
  logic [1:0] chan_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] charge_cyc;
  logic [2:0] shift_amt;
  logic [1:0] last_chan;

  // Code 0 is invalid and is run as the shortest time
  assign shift_amt = (charge_time_code == 3'h0) ? 3'h0 : charge_time_code - 3'h1;
  assign charge_cyc = TIMER_W'(CHARGE_BASE_CYC) << shift_amt;
  assign last_chan = three_electrode_mode ? 2'h2 : 2'h1;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TER_MS_GROUND;
      chan_reg <= 2'h0;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        TER_MS_GROUND: begin
          if (timer_reg == TIMER_W'(GROUND_CYC - 1)) begin
            timer_reg <= '0;
            state_reg <= TER_MS_CHARGE; // RULE_13
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        TER_MS_CHARGE: begin
          if (timer_reg == charge_cyc - 1'b1) begin
            timer_reg <= '0;
            state_reg <= TER_MS_CONVERT; // RULE_15
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
        TER_MS_CONVERT: begin
          if (adc_done) begin
            state_reg <= TER_MS_DISCHARGE;
          end
        end
        TER_MS_DISCHARGE: begin
          // Same duration as the charge phase at the same current
          if (timer_reg == charge_cyc - 1'b1) begin // RULE_16
            timer_reg <= '0;
            state_reg <= TER_MS_GROUND;
            chan_reg <= (chan_reg >= last_chan) ? 2'h0 : chan_reg + 2'h1;
          end else begin
            timer_reg <= timer_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Start pulse on entering conversion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= (state_reg == TER_MS_CHARGE) && (timer_reg == charge_cyc - 1'b1);
    end
  end

  // Switch controls; idle electrodes stay grounded
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive.ground <= '1;
      drive.charge <= '0;
      drive.discharge <= '0;
    end else begin
      for (int i = 0; i < NUM_ELEC; i++) begin
        drive.charge[i] <= (chan_reg == 2'(i)) && (state_reg == TER_MS_CHARGE); // RULE_13
        drive.discharge[i] <= (chan_reg == 2'(i)) && (state_reg == TER_MS_DISCHARGE); // RULE_16
        drive.ground[i] <= (chan_reg != 2'(i)) || (state_reg == TER_MS_GROUND); // RULE_14
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample <= '0;
    end else begin
      sample.valid <= (state_reg == TER_MS_CONVERT) && adc_done;
      if ((state_reg == TER_MS_CONVERT) && adc_done) begin
        sample.chan <= chan_reg;
        sample.value <= adc_data; // RULE_15
      end
    end
  end

endmodule

// *** hdl/ter_top.sv ***
// Touch electrode readout: I2C register slave, filters and interrupt.
// Assumes SCL and SDA are asynchronous pins with external pull-ups, and
// touch status comes from threshold logic on sys_clk.
module ter_top #(
  parameter logic [6:0] I2C_ADDR = ter_pkg::I2C_ADDR_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Shared interrupt / third electrode pin
  output logic irq_b_out,
  output logic irq_b_oe,
  // Configuration
  input wire logic three_electrode_mode,
  input wire logic [2:0] charge_time_code,
  input wire logic [ter_pkg::NUM_ELEC-1:0] touch_status,
  // Analog front end
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ter_pkg::ADC_W-1:0] adc_data,
  output ter_pkg::ter_elec_drive_t drive
);
  import ter_pkg::*;

  ter_sample_t sample;
  logic [ADC_W-1:0] filt_reg [NUM_ELEC];
  logic [ADC_W-1:0] base_reg [NUM_ELEC];
  logic [NUM_ELEC-1:0] primed_reg;
  logic [NUM_ELEC-1:0] status_reg;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_det, stop_det;
  ter_i2c_state_t i2c_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic ptr_done_reg;
  logic rw_reg;
  logic irq_pend_reg;
  logic status_changed;
  logic read_begin;
  logic [7:0] rd_data;

  ter_sequencer u_seq (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .three_electrode_mode(three_electrode_mode),
    .charge_time_code(charge_time_code),
    .adc_start(adc_start),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .drive(drive),
    .sample(sample)
  );

  // Second-level average and third-level baseline per electrode
  genvar g;
  generate
    for (g = 0; g < NUM_ELEC; g++) begin : g_filt
      logic [ADC_W+1:0] filt_sum;
      logic [ADC_W+3:0] base_sum;
      assign filt_sum = {2'b00, filt_reg[g]} + {1'b0, filt_reg[g], 1'b0} + {2'b00, sample.value};
      assign base_sum = {base_reg[g], 4'h0} - {4'h0, base_reg[g]} + {4'h0, filt_reg[g]};
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          filt_reg[g] <= FILT_RESET;
          base_reg[g] <= FILT_RESET;
          primed_reg[g] <= 1'b0;
        end else if (sample.valid && (sample.chan == 2'(g))) begin
          primed_reg[g] <= 1'b1;
          if (!primed_reg[g]) begin
            filt_reg[g] <= sample.value;
            base_reg[g] <= sample.value;
          end else begin
            filt_reg[g] <= filt_sum[ADC_W+1:2];
            base_reg[g] <= base_sum[ADC_W+3:4];
          end
        end
      end
    end
  endgenerate

  // Pin synchronisers; only stages 2 and 3 feed logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // Register read map
  always_comb begin
    rd_data = UNMAPPED_READ;
    unique case (ptr_reg)
      TOUCH_STATUS_OFS: rd_data = {{(8 - NUM_ELEC){1'b0}}, status_reg}; // RULE_18
      E0_FILT_LOW_OFS: rd_data = filt_reg[0][FILT_LOW_MSB:0]; // RULE_01 RULE_03
      E1_FILT_LOW_OFS: rd_data = filt_reg[1][FILT_LOW_MSB:0]; // RULE_01 RULE_03
      E2_FILT_LOW_OFS: rd_data = filt_reg[2][FILT_LOW_MSB:0]; // RULE_01 RULE_03
      E0_FILT_HIGH_OFS: rd_data = {6'h00, filt_reg[0][ADC_W-1:FILT_HIGH_LSB]}; // RULE_02 RULE_04 RULE_20
      E1_FILT_HIGH_OFS: rd_data = {6'h00, filt_reg[1][ADC_W-1:FILT_HIGH_LSB]}; // RULE_02 RULE_04 RULE_20
      E2_FILT_HIGH_OFS: rd_data = {6'h00, filt_reg[2][ADC_W-1:FILT_HIGH_LSB]}; // RULE_02 RULE_04 RULE_20
      E0_BASELINE_OFS: rd_data = base_reg[0][ADC_W-1:BASE_DROP]; // RULE_05 RULE_06
      E1_BASELINE_OFS: rd_data = base_reg[1][ADC_W-1:BASE_DROP]; // RULE_05 RULE_06
      E2_BASELINE_OFS: rd_data = base_reg[2][ADC_W-1:BASE_DROP]; // RULE_05 RULE_06
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  // I2C slave state machine
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      i2c_reg <= TER_IS_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ptr_done_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      i2c_reg <= TER_IS_ADDR;
      bit_cnt_reg <= 4'h0;
      ptr_done_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      i2c_reg <= TER_IS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (i2c_reg)
        TER_IS_IDLE: begin
          sda_oe <= 1'b0;
        end
        TER_IS_ADDR, TER_IS_WRITE: begin
          if (scl_rise) begin
            rx_reg <= {rx_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && (bit_cnt_reg == 4'h8)) begin
            bit_cnt_reg <= 4'h0;
            if (i2c_reg == TER_IS_ADDR) begin
              if (rx_reg[7:1] == I2C_ADDR) begin
                rw_reg <= rx_reg[0];
                sda_oe <= 1'b1;
                i2c_reg <= TER_IS_ADDR_ACK;
              end else begin
                i2c_reg <= TER_IS_IDLE;
              end
            end else begin
              // First written byte sets the pointer; data bytes are dropped
              if (!ptr_done_reg) begin
                ptr_reg <= rx_reg;
              end
              ptr_done_reg <= 1'b1;
              sda_oe <= 1'b1;
              i2c_reg <= TER_IS_WRITE_ACK;
            end
          end
        end
        TER_IS_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              tx_reg <= {rd_data[6:0], 1'b0};
              sda_oe <= !rd_data[7];
              i2c_reg <= TER_IS_READ;
            end else begin
              sda_oe <= 1'b0;
              i2c_reg <= TER_IS_WRITE;
            end
          end
        end
        TER_IS_WRITE_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            i2c_reg <= TER_IS_WRITE;
          end
        end
        TER_IS_READ: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              sda_oe <= 1'b0;
              ptr_reg <= ptr_reg + 8'h01;
              i2c_reg <= TER_IS_READ_ACK;
            end else begin
              sda_oe <= !tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        TER_IS_READ_ACK: begin
          if (scl_rise && sda_s2) begin
            i2c_reg <= TER_IS_IDLE;
          end else if (scl_fall) begin
            tx_reg <= {rd_data[6:0], 1'b0};
            sda_oe <= !rd_data[7];
            i2c_reg <= TER_IS_READ;
          end
        end
        default: begin
          i2c_reg <= TER_IS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // SDA only ever pulls low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Read transaction acknowledged by this device
  assign read_begin = (i2c_reg == TER_IS_ADDR_ACK) && rw_reg && scl_fall;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
    end else begin
      status_reg <= touch_status;
    end
  end

  // Touch or release on any electrode flips a status bit
  assign status_changed = (touch_status != status_reg); // RULE_08 RULE_09

  // Set wins over a read clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pend_reg <= 1'b0;
    end else if (status_changed) begin
      irq_pend_reg <= 1'b1; // RULE_07 RULE_10
    end else if (read_begin) begin
      irq_pend_reg <= 1'b0; // RULE_11
    end
  end

  // Open-drain pin, released when the pin serves as the third electrode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b_out <= 1'b0;
      irq_b_oe <= 1'b0;
    end else begin
      irq_b_out <= 1'b0;
      irq_b_oe <= (irq_pend_reg || status_changed) && !three_electrode_mode; // RULE_10 RULE_19
    end
  end

endmodule

// *** dv/ter_monitor.sv ***
// Assertion checker for the touch readout top level.
// Sees only ter_top ports; bound to every ter_top instance.
module ter_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_out,
  // Interrupt pin
  input wire logic irq_b_out,
  input wire logic irq_b_oe,
  // Configuration
  input wire logic three_electrode_mode,
  input wire logic [2:0] charge_time_code,
  input wire logic [ter_pkg::NUM_ELEC-1:0] touch_status,
  // Analog front end
  input wire logic adc_start,
  input wire logic adc_done,
  input wire ter_pkg::ter_elec_drive_t drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import ter_pkg::*;
  logic chg_on, dis_on;
  logic [2:0] code_reg;
  logic [TIMER_W-1:0] chg_cnt_reg, dis_cnt_reg, last_reg, chg_exp;
  assign chg_on = |drive.charge;
  assign dis_on = |drive.discharge;
  assign chg_exp = TIMER_W'(CHARGE_BASE_CYC) << ((code_reg == 3'h0) ? 3'h0 : code_reg - 3'h1);
  // Length of the running charge and discharge phases
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_cnt_reg <= '0;
      dis_cnt_reg <= '0;
    end else begin
      chg_cnt_reg <= chg_on ? chg_cnt_reg + 1'b1 : '0;
      dis_cnt_reg <= dis_on ? dis_cnt_reg + 1'b1 : '0;
    end
  end
  // Code seen as charging began, and length of the last charge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_reg <= 3'h0;
      last_reg <= '0;
    end else begin
      if (chg_on && chg_cnt_reg == '0) begin
        code_reg <= charge_time_code;
      end
      if (!chg_on && chg_cnt_reg != '0) begin
        last_reg <= chg_cnt_reg;
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_charge_end;
    chg_on ##1 !chg_on;
  endsequence
  sequence s_charge_begin;
    !chg_on ##1 chg_on;
  endsequence
  a_irq_on_change: assert property (
    $changed(touch_status) && !three_electrode_mode |=> irq_b_oe || three_electrode_mode)
    else $error("interrupt missed a status change");
  a_irq_no_cause: assert property (
    !irq_b_oe && !$changed(touch_status) |=> !irq_b_oe) else $error("interrupt without a change");
  a_irq_latches: assert property (
    irq_b_oe && scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
    |=> irq_b_oe || three_electrode_mode) else $error("interrupt dropped without a read");
  a_irq_off_three: assert property (
    three_electrode_mode && $past(three_electrode_mode) |-> !irq_b_oe) else $error("interrupt in three mode");
  a_pins_open_drain: assert property (!irq_b_out && !sda_out) else $error("pin driven high");
  a_others_grounded: assert property (
    $onehot0(drive.charge | drive.discharge) && ((drive.charge | drive.discharge) & drive.ground) == '0
    && $countones(drive.ground) >= NUM_ELEC - 1) else $error("idle electrode not grounded");
  a_ground_first: assert property (
    s_charge_begin |-> ($past(drive.ground, 8) & $past(drive.ground) & drive.charge) == drive.charge)
    else $error("charge without grounding");
  a_charge_length: assert property (
    $fell(chg_on) && charge_time_code == code_reg |-> chg_cnt_reg == chg_exp) else $error("charge time wrong");
  a_start_after_charge: assert property (
    s_charge_end |-> $past(adc_start)) else $error("no conversion after charge");
  a_start_pulse: assert property (adc_start |=> !adc_start) else $error("start longer than a cycle");
  a_discharge_follows: assert property (
    adc_done |-> ##[1:3] dis_on) else $error("no discharge after conversion");
  a_discharge_length: assert property (
    $fell(dis_on) |-> dis_cnt_reg == last_reg) else $error("discharge length differs");
endmodule

bind ter_top ter_monitor u_mon (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .irq_b_out(irq_b_out),
  .irq_b_oe(irq_b_oe),
  .three_electrode_mode(three_electrode_mode),
  .charge_time_code(charge_time_code),
  .touch_status(touch_status),
  .adc_start(adc_start),
  .adc_done(adc_done),
  .drive(drive)
);

// *** dv/ter_host_model.sv ***
// Host controller model: bus master on the two-wire pins, 320 ns bit time.
// Assumes pull-ups on both lines, resolved in the bench.
module ter_host_model #(
  parameter logic [6:0] DEV_ADDR = ter_pkg::I2C_ADDR_DEFAULT
) (
  // Clock
  input wire logic sys_clk,
  // Bus lines
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import ter_pkg::*;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Data moves one cycle after the clock falls, sampled late in the high phase
  task automatic send_bit(input logic b, output logic r);
    wait_cyc(1);
    sda_oe <= !b;
    wait_cyc(3);
    scl_oe <= 1'b0;
    wait_cyc(4);
    r = sda_in;
    scl_oe <= 1'b1;
  endtask
  task automatic start_cond;
    wait_cyc(1);
    sda_oe <= 1'b0;
    wait_cyc(3);
    scl_oe <= 1'b0;
    wait_cyc(4);
    sda_oe <= 1'b1;
    wait_cyc(4);
    scl_oe <= 1'b1;
  endtask
  task automatic stop_cond;
    wait_cyc(1);
    sda_oe <= 1'b1;
    wait_cyc(3);
    scl_oe <= 1'b0;
    wait_cyc(4);
    sda_oe <= 1'b0;
    wait_cyc(4);
  endtask
  task automatic xfer_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r, output logic nak);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i], x);
      r[i] = x;
    end
    send_bit(ack_in, nak);
  endtask
  task automatic addr_only(input logic [6:0] a, output logic nak);
    logic [7:0] r;
    start_cond();
    xfer_byte({a, 1'b0}, 1'b1, r, nak);
    stop_cond();
  endtask
  // Sets the pointer, then reads two bytes after a repeated start
  task automatic read_pair(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1, output logic nak);
    logic [7:0] r;
    logic a, b, c;
    start_cond();
    xfer_byte({DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer_byte(ptr, 1'b1, r, b);
    start_cond();
    xfer_byte({DEV_ADDR, 1'b1}, 1'b1, r, c);
    nak = a | b | c;
    xfer_byte(8'hff, 1'b0, d0, a);
    xfer_byte(8'hff, 1'b1, d1, a);
    stop_cond();
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the touch readout top level.
// Host model on the bus pins; a behavioural converter answers adc_start.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ter_pkg::*;
  logic sys_clk, rst_b, scl_in, sda_in, sda_out, sda_oe, irq_b_out, irq_b_oe, irq_pin;
  logic three_electrode_mode, adc_start, adc_done, h_scl_oe, h_sda_oe;
  logic [2:0] charge_time_code;
  logic [NUM_ELEC-1:0] touch_status;
  logic [ADC_W-1:0] adc_data;
  logic [ADC_W-1:0] conv_val [NUM_ELEC];
  logic [1:0] chan;
  logic [3:0] adc_wait;
  ter_elec_drive_t drive;
  int fails, check_count, cycles;
  // Pull-ups on every open-drain line
  assign scl_in = !h_scl_oe;
  assign sda_in = !(h_sda_oe || (sda_oe && !sda_out));
  assign irq_pin = !(irq_b_oe && !irq_b_out);
  ter_top u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq_b_out(irq_b_out), .irq_b_oe(irq_b_oe),
    .three_electrode_mode(three_electrode_mode), .charge_time_code(charge_time_code),
    .touch_status(touch_status), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .drive(drive)
  );
  ter_host_model u_host (.sys_clk(sys_clk), .sda_in(sda_in), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = !sys_clk;
  end
  // Converter answers five cycles after a start with the measured electrode's level
  always @(posedge sys_clk) begin
    adc_done <= !adc_start && (adc_wait == 4'h1);
    if (|drive.charge) begin
      chan <= drive.charge[0] ? 2'h0 : (drive.charge[1] ? 2'h1 : 2'h2);
    end
    if (adc_start) begin
      adc_wait <= 4'h5;
    end else if (adc_wait != 4'h0) begin
      adc_wait <= adc_wait - 4'h1;
      if (adc_wait == 4'h1) begin
        adc_data <= conv_val[chan];
      end
    end
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      $display("unexpected %0t timeout", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic test_regs;
    logic [7:0] lo, hi;
    logic nak;
    for (int e = 0; e < NUM_ELEC; e++) begin
      u_host.read_pair(E0_FILT_LOW_OFS + 8'(2 * e), lo, hi, nak);
      chk({7'h0, nak}, 8'h00);
      chk(lo, conv_val[e][7:0]);
      chk(hi, {6'h00, conv_val[e][9:8]});
    end
    u_host.read_pair(E0_BASELINE_OFS, lo, hi, nak);
    chk(lo, conv_val[0][9:2]);
    chk(hi, conv_val[1][9:2]);
    u_host.read_pair(E2_BASELINE_OFS, lo, hi, nak);
    chk(lo, conv_val[2][9:2]);
    chk(hi, UNMAPPED_READ);
    $display("test_regs done");
  endtask
  // Every charge code, switched while an electrode sits grounded
  task automatic test_charge;
    logic [7:0] lo, hi;
    logic nak;
    for (int c = 0; c < 8; c++) begin
      wait (|drive.discharge);
      wait (!(|drive.discharge));
      repeat (10) @(posedge sys_clk);
      charge_time_code <= 3'(c);
      repeat (3) begin
        wait (|drive.charge);
        wait (!(|drive.charge));
      end
    end
    u_host.read_pair(E1_FILT_LOW_OFS, lo, hi, nak);
    chk(lo, conv_val[1][7:0]);
    $display("test_charge done");
  endtask
  task automatic test_irq;
    logic [7:0] st, nx;
    logic nak;
    three_electrode_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({7'h0, irq_pin}, 8'h01);
    for (int b = 0; b < 2; b++) begin
      for (int v = 1; v >= 0; v--) begin
        touch_status <= v ? 3'(1 << b) : 3'h0;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, irq_pin}, 8'h00);
        u_host.addr_only(I2C_ADDR_DEFAULT ^ 7'h01, nak);
        chk({7'h0, nak}, 8'h01);
        chk({7'h0, irq_pin}, 8'h00);
        u_host.read_pair(TOUCH_STATUS_OFS, st, nx, nak);
        chk(st, v ? 8'(1 << b) : 8'h00);
        chk({7'h0, irq_pin}, 8'h01);
      end
    end
    $display("test_irq done");
  endtask
  task automatic test_three;
    logic [7:0] st, nx;
    logic nak;
    three_electrode_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    touch_status <= 3'h5;
    repeat (3) @(posedge sys_clk);
    chk({7'h0, irq_pin}, 8'h01);
    u_host.read_pair(TOUCH_STATUS_OFS, st, nx, nak);
    chk(st, 8'h05);
    $display("test_three done");
  endtask
  initial begin
    rst_b = 1'b0;
    three_electrode_mode = 1'b1;
    charge_time_code = 3'h1;
    touch_status = 3'h0;
    adc_done = 1'b0;
    adc_data = 10'h000;
    adc_wait = 4'h0;
    chan = 2'h0;
    fails = 0;
    check_count = 0;
    cycles = 0;
    conv_val = '{10'h1a6, 10'h21d, 10'h26f};
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (1000) @(posedge sys_clk);
    test_regs();
    test_charge();
    test_irq();
    test_three();
    finish_test();
  end
endmodule
